// File: core/dim_regs.svh
// What this block does
// [R1] two direct inputs; after reset input a drives channel 2, input b channel 3
// [R2] each input has a route register choosing which channels it drives
// [R3] each channel is serial on-bit OR every input routed to it
// [R4] input level monitor register shows current level of each input
// [R5] input level monitor keeps updating during limp-home mode
// [R6] sleep pin low with an input high: limp-home, default channels only
// [R7] sleep pin low with both inputs low: sleep mode
// [R8] controller holds a new sleep pin level for the minimum transition time
// [R9] while sleep pin low, route and output control registers held at defaults
// [R10] sleep pin and inputs all low: undervoltage detection disabled
// [R11] sleep pin and inputs all low: serial transfers refused, output high-z
// [R12] route register defaults hold only the input's default channel
`ifndef DIM_REGS_SVH
`define DIM_REGS_SVH
`define DIM_NCH 8
`define DIM_ROUTE_A_RST 8'h04
`define DIM_ROUTE_B_RST 8'h08
`define DIM_OUT_RST 8'h00
`define DIM_CH_A_DEF 2
`define DIM_CH_B_DEF 3
`endif

// File: core/dim_pkg.sv
package dim_pkg;
  typedef enum logic [1:0] {
    DIM_ACTIVE,
    DIM_LIMP,
    DIM_SLEEP
  } dim_mode_type;
  typedef logic [7:0] dim_chan_type;
endpackage

// File: core/dim_mode_dec.sv
`timescale 1ns/1ps
`include "dim_regs.svh"
module dim_mode_dec (
  input wire logic wake_i,
  input wire logic in_a_i,
  input wire logic in_b_i,
  output dim_pkg::dim_mode_type mode_o
);
  wire any_in = in_a_i | in_b_i;
  // sleep pin low picks sleep or limp-home from input levels
  assign mode_o = wake_i ? dim_pkg::DIM_ACTIVE :
                  (any_in ? dim_pkg::DIM_LIMP : dim_pkg::DIM_SLEEP); // [R6] [R7]
endmodule

// File: core/dim_direct_input.sv
`timescale 1ns/1ps
`include "dim_regs.svh"
module dim_direct_input (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic direct_input_a_i,
  input wire logic direct_input_b_i,
  input wire logic wake_i,
  input wire logic route_a_we_i,
  input wire logic route_b_we_i,
  input wire logic out_we_i,
  input wire logic [7:0] wdata_i,
  input wire logic serial_cs_n_i,
  input wire logic serial_so_i,
  output logic [7:0] channel_o,
  output logic [7:0] input_a_route_register_o,
  output logic [7:0] input_b_route_register_o,
  output logic [7:0] out_ctrl_o,
  output logic [1:0] input_level_monitor_register_o,
  output logic [1:0] mode_o,
  output logic uv_detect_en_o,
  output logic serial_en_o,
  output logic serial_so_o,
  output logic serial_so_oe_o
);
  dim_pkg::dim_chan_type route_a_q, route_b_q, out_q;
  dim_pkg::dim_chan_type route_a_d, route_b_d, out_d, chan_d;
  logic [7:0] chan_q;
  logic [1:0] inmon_q;
  dim_pkg::dim_mode_type mode_q, mode_w;
  logic uv_q, sen_q, so_q, so_oe_q;

  dim_mode_dec u_mode (
    .wake_i(wake_i),
    .in_a_i(direct_input_a_i),
    .in_b_i(direct_input_b_i),
    .mode_o(mode_w)
  );

  function automatic dim_pkg::dim_chan_type onehot(input int idx);
    onehot = 8'h01 << idx;
  endfunction

  wire limp = (mode_w == dim_pkg::DIM_LIMP);
  wire sleeping = (mode_w == dim_pkg::DIM_SLEEP);
  wire active = (mode_w == dim_pkg::DIM_ACTIVE);

  // registers are held at defaults whenever the sleep pin is low
  assign route_a_d = !active ? `DIM_ROUTE_A_RST :
                     (route_a_we_i ? wdata_i : route_a_q); // [R2] [R9] [R12]
  assign route_b_d = !active ? `DIM_ROUTE_B_RST :
                     (route_b_we_i ? wdata_i : route_b_q); // [R2] [R9] [R12]
  assign out_d = !active ? `DIM_OUT_RST : (out_we_i ? wdata_i : out_q); // [R9]
  // limp-home ignores routing and serial bits: only default channels
  wire [7:0] limp_ch = ({8{direct_input_a_i}} & onehot(`DIM_CH_A_DEF)) |
                       ({8{direct_input_b_i}} & onehot(`DIM_CH_B_DEF)); // [R1] [R6]
  wire [7:0] norm_ch = out_q | ({8{direct_input_a_i}} & route_a_q) |
                       ({8{direct_input_b_i}} & route_b_q); // [R3]
  assign chan_d = limp ? limp_ch : (sleeping ? 8'h00 : norm_ch);

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      route_a_q <= `DIM_ROUTE_A_RST; // [R1] [R12]
      route_b_q <= `DIM_ROUTE_B_RST;
      out_q <= `DIM_OUT_RST;
      chan_q <= 8'h00;
      inmon_q <= 2'h0;
      mode_q <= dim_pkg::DIM_SLEEP;
      uv_q <= 1'b0;
      sen_q <= 1'b0;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      route_a_q <= route_a_d;
      route_b_q <= route_b_d;
      out_q <= out_d;
      chan_q <= chan_d;
      inmon_q <= {direct_input_b_i, direct_input_a_i}; // [R4] [R5]
      mode_q <= mode_w;
      uv_q <= !sleeping; // [R10]
      sen_q <= !sleeping; // [R11]
      so_q <= serial_so_i;
      so_oe_q <= !sleeping && !serial_cs_n_i; // [R11]
    end
  end

  assign channel_o = chan_q;
  assign input_a_route_register_o = route_a_q;
  assign input_b_route_register_o = route_b_q;
  assign out_ctrl_o = out_q;
  assign input_level_monitor_register_o = inmon_q;
  assign mode_o = mode_q;
  assign uv_detect_en_o = uv_q;
  assign serial_en_o = sen_q;
  assign serial_so_o = so_q;
  assign serial_so_oe_o = so_oe_q;

  // [R8] the controller holds the sleep pin; the mode follows one edge later

  chk_channel_or: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $past(active) |-> channel_o == ($past(out_q) | ($past(route_a_q) & {8{$past(direct_input_a_i)}})
      | ($past(route_b_q) & {8{$past(direct_input_b_i)}}))) // [R3]
    else $error("channel not or of serial bits and routed inputs");
  chk_limp_default: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $past(limp) |-> channel_o == {4'h0, $past(direct_input_b_i), $past(direct_input_a_i), 2'h0}) // [R6]
    else $error("limp-home channels wrong");
  chk_sleep_off: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $past(sleeping) |-> channel_o == 8'h00 && !uv_detect_en_o) // [R7] [R10]
    else $error("sleep mode leaves channel or uv on");
  chk_regs_default: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !$past(wake_i) |-> route_a_q == 8'h04 && route_b_q == 8'h08 && out_q == 8'h00) // [R9]
    else $error("registers not default while sleep pin low");
  chk_monitor_track: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ##1 input_level_monitor_register_o == {$past(direct_input_b_i), $past(direct_input_a_i)}) // [R4]
    else $error("input monitor stale");
  chk_monitor_limp: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    limp && direct_input_a_i |=> input_level_monitor_register_o[0]) // [R5]
    else $error("monitor frozen in limp-home");
  chk_so_quiet: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    sleeping && !serial_cs_n_i |=> !serial_so_oe_o && !serial_en_o) // [R11]
    else $error("serial output driven in sleep");
  chk_route_write: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    active && route_a_we_i |=> route_a_q == $past(wdata_i)) // [R2]
    else $error("route register write lost");
  cov_limp: cover property (@(posedge sys_clk_i) limp);
  cov_sleep: cover property (@(posedge sys_clk_i) sleeping);
  cov_routed: cover property (@(posedge sys_clk_i) active && direct_input_a_i && route_a_q != 8'h04);
endmodule

// File: test/dim_mcu_model.sv
`timescale 1ns/1ps
module dim_mcu_model #(
  parameter int HOLD_CYC = 4
) (
  input wire logic sys_clk_i,
  output logic in_a_o,
  output logic in_b_o,
  output logic wake_o
);
  initial begin
    in_a_o = 1'b0;
    in_b_o = 1'b0;
    wake_o = 1'b1;
  end
  // pins move just after an edge, then stand for the minimum hold time
  task automatic drive(input logic a, input logic b, input logic w);
    @(posedge sys_clk_i);
    #1;
    in_a_o = a;
    in_b_o = b;
    wake_o = w;
    repeat (HOLD_CYC) @(posedge sys_clk_i);
    #1;
  endtask
endmodule

// File: test/direct_input_mode_control_test.sv
`timescale 1ns/1ps
module direct_input_mode_control_test;
  logic sys_clk_i, nrst_i, route_a_we_i, route_b_we_i, out_we_i, serial_cs_n_i, serial_so_i;
  logic direct_input_a_i, direct_input_b_i, wake_i, uv_detect_en_o, serial_en_o;
  logic serial_so_o, serial_so_oe_o;
  logic [7:0] wdata_i, channel_o, input_a_route_register_o, input_b_route_register_o, out_ctrl_o;
  logic [1:0] input_level_monitor_register_o, mode_o;
  int failures = 0;
  int n_compared = 0;
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  dim_mcu_model mcu (.sys_clk_i(sys_clk_i), .in_a_o(direct_input_a_i),
    .in_b_o(direct_input_b_i), .wake_o(wake_i));
  dim_direct_input uut (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .direct_input_a_i(direct_input_a_i),
    .direct_input_b_i(direct_input_b_i),
    .wake_i(wake_i),
    .route_a_we_i(route_a_we_i),
    .route_b_we_i(route_b_we_i),
    .out_we_i(out_we_i),
    .wdata_i(wdata_i),
    .serial_cs_n_i(serial_cs_n_i),
    .serial_so_i(serial_so_i),
    .channel_o(channel_o),
    .input_a_route_register_o(input_a_route_register_o),
    .input_b_route_register_o(input_b_route_register_o),
    .out_ctrl_o(out_ctrl_o),
    .input_level_monitor_register_o(input_level_monitor_register_o),
    .mode_o(mode_o),
    .uv_detect_en_o(uv_detect_en_o),
    .serial_en_o(serial_en_o),
    .serial_so_o(serial_so_o),
    .serial_so_oe_o(serial_so_oe_o)
  );
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input int sel, input logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    route_a_we_i = (sel == 0);
    route_b_we_i = (sel == 1);
    out_we_i = (sel == 2);
    wdata_i = d;
    @(posedge sys_clk_i);
    #1;
    {route_a_we_i, route_b_we_i, out_we_i} = 3'h0;
  endtask
  task automatic conclude();
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    conclude();
  end
  initial begin
    nrst_i = 1'b0;
    {route_a_we_i, route_b_we_i, out_we_i, serial_so_i} = 4'h0;
    serial_cs_n_i = 1'b1;
    wdata_i = 8'h00;
    repeat (20) @(posedge sys_clk_i);
    #1;
    nrst_i = 1'b1;
    mcu.drive(1'b1, 1'b0, 1'b1);
    chk("channel", 8'h04, channel_o);
    chk("monitor", 8'h01, input_level_monitor_register_o);
    mcu.drive(1'b0, 1'b1, 1'b1);
    chk("channel", 8'h08, channel_o);
    chk("monitor", 8'h02, input_level_monitor_register_o);
    wr(0, 8'h81);
    wr(2, 8'h10);
    chk("route_a", 8'h81, input_a_route_register_o);
    chk("out_ctrl", 8'h10, out_ctrl_o);
    mcu.drive(1'b1, 1'b1, 1'b1);
    chk("channel", 8'h99, channel_o);
    // limp-home: defaults back, only the default channel of input a
    mcu.drive(1'b1, 1'b0, 1'b0);
    chk("mode", 8'h01, mode_o);
    chk("channel", 8'h04, channel_o);
    chk("route_a", 8'h04, input_a_route_register_o);
    chk("out_ctrl", 8'h00, out_ctrl_o);
    chk("monitor", 8'h01, input_level_monitor_register_o);
    wr(1, 8'hff);
    chk("route_b", 8'h08, input_b_route_register_o);
    serial_cs_n_i = 1'b0;
    serial_so_i = 1'b1;
    mcu.drive(1'b0, 1'b0, 1'b0);
    chk("mode", 8'h02, mode_o);
    chk("channel", 8'h00, channel_o);
    chk("uv_detect", 8'h00, uv_detect_en_o);
    chk("so_oe", 8'h00, serial_so_oe_o);
    chk("serial_en", 8'h00, serial_en_o);
    mcu.drive(1'b0, 1'b0, 1'b1);
    chk("mode", 8'h00, mode_o);
    chk("uv_detect", 8'h01, uv_detect_en_o);
    chk("serial_en", 8'h01, serial_en_o);
    chk("so_oe", 8'h01, serial_so_oe_o);
    chk("so", 8'h01, serial_so_o);
    conclude();
  end
endmodule
